// [design/ppd_pkg.sv]
// Shared constants, register map and carrier types of the peer-delay capture bank
package ppd_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int PPD_ADDR_W = 10;
    localparam logic [9:0] PPD_OFS_SELECT = 10'h100;
    localparam logic [9:0] PPD_OFS_CMD_CTL = 10'h104;
    localparam logic [9:0] PPD_OFS_TX_PARSE = 10'h158;
    localparam logic [9:0] PPD_OFS_PD_SEC = 10'h178;
    localparam logic [9:0] PPD_OFS_PD_NS = 10'h17C;
    localparam logic [9:0] PPD_OFS_PD_CF_HI = 10'h180;
    localparam logic [9:0] PPD_OFS_PD_CF_LO = 10'h184;
    localparam logic [9:0] PPD_OFS_CSUM_CNT = 10'h188;
    localparam logic [9:0] PPD_OFS_FILT_CNT = 10'h18C;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int PPD_SEL_BANK_LSB = 0;
    localparam int PPD_SEL_PORT_LSB = 4;
    localparam logic [2:0] PPD_BANK_RX = 3'h1;
    localparam logic [2:0] PPD_BANK_TX = 3'h2;
    localparam logic [2:0] PPD_SEL_BANK_RST = 3'h0;
    localparam logic [1:0] PPD_SEL_PORT_RST = 2'h0;
    localparam int PPD_CTL_ENABLE_BIT = 0;
    localparam int PPD_NS_AUTO_BIT = 31;
    localparam int PPD_SEC_W = 4;
    localparam int PPD_NS_W = 30;
    localparam int PPD_CF_LO_LSB = 16;
    localparam int PPD_CF_LO_W = 16;
    localparam int PPD_TX_PARSE_LSB = 11;
    localparam logic [3:0] PPD_TX_PARSE_RST = 4'hE;
    localparam int PPD_TX_PEER_L2_IDX = 3;
    localparam int PPD_TX_GEN_L2_IDX = 2;
    localparam int PPD_TX_IP129_IDX = 1;
    localparam int PPD_TX_IP130_IDX = 0;

    // ------------------------------------------------------------
    // Recognised destination addresses
    // ------------------------------------------------------------
    localparam logic [47:0] PPD_MAC_L2_PEER = 48'h0180_C200_000E;
    localparam logic [47:0] PPD_MAC_L2_GEN = 48'h011B_1900_0000;
    localparam logic [47:0] PPD_MAC_V4_129 = 48'h0100_5E00_0181;
    localparam logic [47:0] PPD_MAC_V4_130 = 48'h0100_5E00_0182;
    localparam logic [47:0] PPD_MAC_V6_129 = 48'h3333_0000_0181;
    localparam logic [47:0] PPD_MAC_V6_130 = 48'h3333_0000_0182;
    localparam logic [31:0] PPD_IP4_129 = 32'hE000_0181;
    localparam logic [31:0] PPD_IP4_130 = 32'hE000_0182;
    localparam logic [15:0] PPD_IP6_TAIL_129 = 16'h0181;
    localparam logic [15:0] PPD_IP6_TAIL_130 = 16'h0182;
    localparam logic [7:0] PPD_IP6_MCAST = 8'hFF;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] capture_seconds;
        logic [29:0] capture_nanoseconds;
        logic [63:0] residence_correction;
    } ppd_pdreq_type;

    typedef struct packed {
        logic valid;
        logic ipv6;
        logic [47:0] dst_mac;
        logic [31:0] ip4_dst;
        logic [127:0] ip6_dst;
    } ppd_tx_frame_type;

    typedef struct packed {
        logic [2:0] bank;
        logic [1:0] port;
    } ppd_select_type;

    // Byte-enable merge of a write into a stored word
    function automatic logic [31:0] ppd_merge(input logic [31:0] old_value,
                                              input logic [31:0] wr_value,
                                              input logic [3:0] be);
        logic [31:0] mask;
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_value & ~mask) | (wr_value & mask);
    endfunction

endpackage

// [design/ppd_port_capture.sv]
// Per-port peer-delay capture, drop counters and transmit parse enables
//
// Contract
// - With auto set, a received peer-delay request loads time and correction fields.
// - With auto clear (reset), hardware leaves those fields for software alone.
// - Seconds register: 4-bit writable value in 3:0, zero reset, rest read-only.
// - Nanoseconds register: 30-bit writable value in 29:0, bit 30 read-only.
// - Correction high register holds correction bits 63:32, writable, zero reset.
// - Correction low register keeps bits 31:16 only; bits 15:0 read as reserved.
// - Checksum drop counter counts each ingress drop for bad UDP checksum.
// - Filter drop counter counts each ingress drop by message filtering.
// - Each such dropped packet is also flagged as an errored frame to the MAC.
// - Both drop counters stop at all ones and never wrap.
// - Writing zero clears a counter; a coincident increment may be lost.
// - Parse bit 14, reset one, accepts destination 01:80:C2:00:00:0E.
// - Parse bit 13, reset one, accepts destination 01:1B:19:00:00:00.
// - Parse bit 12, reset one, accepts IPv4 group 224.0.1.129 with its MAC.
// - Parse bit 12 also accepts IPv6 MAC 33:33:00:00:01:81, any-scope ::181.
// - Parse bit 11, reset zero, accepts group 224.0.1.130 and IPv6 ::182.
// - A bank select field picks the bank, a port select field the port instance.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps

module ppd_port_capture #(
    parameter int NUM_PORTS = 3,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [ppd_pkg::PPD_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receive events per port
    input wire logic [NUM_PORTS-1:0] pdreq_valid,
    input wire ppd_pkg::ppd_pdreq_type [NUM_PORTS-1:0] pdreq_time,
    input wire logic [NUM_PORTS-1:0] csum_drop,
    input wire logic [NUM_PORTS-1:0] filter_drop,
    output logic [NUM_PORTS-1:0] rx_mac_error,
    // Transmit classification per port
    input wire ppd_pkg::ppd_tx_frame_type [NUM_PORTS-1:0] tx_frame,
    output logic [NUM_PORTS-1:0] tx_ptp_valid,
    output logic [NUM_PORTS-1:0] tx_is_ptp,
    // Global state
    output logic ptp_enable
);
    import ppd_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    logic waitrequest_reg;
    logic [31:0] readdata_reg;
    ppd_select_type select_reg;
    logic enable_reg;
    logic [NUM_PORTS-1:0] auto_reg;
    logic [PPD_SEC_W-1:0] sec_reg [NUM_PORTS];
    logic [PPD_NS_W-1:0] ns_reg [NUM_PORTS];
    logic [31:0] cf_hi_reg [NUM_PORTS];
    logic [PPD_CF_LO_W-1:0] cf_lo_reg [NUM_PORTS];
    logic [CNT_W-1:0] csum_cnt_reg [NUM_PORTS];
    logic [CNT_W-1:0] filt_cnt_reg [NUM_PORTS];
    logic [3:0] tx_parse_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] mac_error_reg;
    logic [NUM_PORTS-1:0] tx_valid_reg;
    logic [NUM_PORTS-1:0] tx_ptp_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr_fire;
    logic port_ok;
    logic rx_bank;
    logic tx_bank;
    logic [31:0] rd_value;
    logic [31:0] sel_word;

    assign req = avs_read | avs_write;
    // Write lands on the edge where the master sees waitrequest low
    assign wr_fire = avs_write & ~waitrequest_reg;
    assign port_ok = int'(select_reg.port) < NUM_PORTS;
    assign rx_bank = (select_reg.bank == PPD_BANK_RX) & port_ok;
    assign tx_bank = (select_reg.bank == PPD_BANK_TX) & port_ok;
    assign sel_word = {26'h000_0000, select_reg.port, 1'b0, select_reg.bank};

    always_comb begin
        rd_value = 32'h0000_0000;
        case (avs_address)
            PPD_OFS_SELECT: begin
                rd_value = sel_word;
            end
            PPD_OFS_CMD_CTL: begin
                rd_value[PPD_CTL_ENABLE_BIT] = enable_reg;
            end
            PPD_OFS_TX_PARSE: begin
                if (tx_bank) begin
                    rd_value[PPD_TX_PARSE_LSB +: 4] = tx_parse_reg[select_reg.port];
                end
            end
            PPD_OFS_PD_SEC: begin
                if (rx_bank) begin
                    rd_value[PPD_SEC_W-1:0] = sec_reg[select_reg.port];
                end
            end
            PPD_OFS_PD_NS: begin
                if (rx_bank) begin
                    rd_value[PPD_NS_W-1:0] = ns_reg[select_reg.port];
                    rd_value[PPD_NS_AUTO_BIT] = auto_reg[select_reg.port];
                end
            end
            PPD_OFS_PD_CF_HI: begin
                if (rx_bank) begin
                    rd_value = cf_hi_reg[select_reg.port];
                end
            end
            PPD_OFS_PD_CF_LO: begin
                if (rx_bank) begin
                    rd_value[PPD_CF_LO_LSB +: PPD_CF_LO_W] = cf_lo_reg[select_reg.port];
                end
            end
            PPD_OFS_CSUM_CNT: begin
                if (rx_bank) begin
                    rd_value = 32'(csum_cnt_reg[select_reg.port]);
                end
            end
            PPD_OFS_FILT_CNT: begin
                if (rx_bank) begin
                    rd_value = 32'(filt_cnt_reg[select_reg.port]);
                end
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Avalon handshake: one wait cycle, then a one-cycle answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            waitrequest_reg <= 1'b1;
        end else if (req && waitrequest_reg) begin
            waitrequest_reg <= 1'b0;
        end else begin
            waitrequest_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && waitrequest_reg) begin
            readdata_reg <= rd_value;
        end
    end

    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            select_reg.bank <= PPD_SEL_BANK_RST;
            select_reg.port <= PPD_SEL_PORT_RST;
        end else if (wr_fire && avs_address == PPD_OFS_SELECT && avs_byteenable[0]) begin
            select_reg.bank <= avs_writedata[PPD_SEL_BANK_LSB +: 3];
            select_reg.port <= avs_writedata[PPD_SEL_PORT_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enable_reg <= 1'b0;
        end else if (wr_fire && avs_address == PPD_OFS_CMD_CTL && avs_byteenable[0]) begin
            enable_reg <= avs_writedata[PPD_CTL_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Peer-delay capture registers
    // ------------------------------------------------------------
    // Hardware capture takes precedence over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                sec_reg[p] <= '0;
                ns_reg[p] <= '0;
                cf_hi_reg[p] <= 32'h0000_0000;
                cf_lo_reg[p] <= 16'h0000;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (auto_reg[p] && pdreq_valid[p]) begin
                    sec_reg[p] <= pdreq_time[p].capture_seconds;
                    ns_reg[p] <= pdreq_time[p].capture_nanoseconds;
                    cf_hi_reg[p] <= pdreq_time[p].residence_correction[63:32];
                    cf_lo_reg[p] <= pdreq_time[p].residence_correction[31:16];
                end else if (wr_fire && rx_bank && select_reg.port == 2'(p)) begin
                    if (avs_address == PPD_OFS_PD_SEC) begin
                        sec_reg[p] <= 4'(ppd_merge(32'(sec_reg[p]), avs_writedata,
                                                   avs_byteenable));
                    end
                    if (avs_address == PPD_OFS_PD_NS) begin
                        ns_reg[p] <= 30'(ppd_merge(32'(ns_reg[p]), avs_writedata,
                                                   avs_byteenable));
                    end
                    if (avs_address == PPD_OFS_PD_CF_HI) begin
                        cf_hi_reg[p] <= ppd_merge(cf_hi_reg[p], avs_writedata,
                                                  avs_byteenable);
                    end
                    if (avs_address == PPD_OFS_PD_CF_LO) begin
                        cf_lo_reg[p] <= 16'(ppd_merge({cf_lo_reg[p], 16'h0000}, avs_writedata,
                                                      avs_byteenable) >> PPD_CF_LO_LSB);
                    end
                end
            end
        end
    end

    // Mode bits are taken as written; software keeps them still while enabled
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            auto_reg <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_fire && rx_bank && select_reg.port == 2'(p) &&
                    avs_address == PPD_OFS_PD_NS && avs_byteenable[3]) begin
                    auto_reg[p] <= avs_writedata[PPD_NS_AUTO_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Drop counters
    // ------------------------------------------------------------
    // A software write wins over a coincident increment
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                csum_cnt_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_fire && rx_bank && select_reg.port == 2'(p) &&
                    avs_address == PPD_OFS_CSUM_CNT) begin
                    csum_cnt_reg[p] <= CNT_W'(ppd_merge(32'(csum_cnt_reg[p]), avs_writedata,
                                                        avs_byteenable));
                end else if (csum_drop[p] && csum_cnt_reg[p] != CNT_MAX) begin
                    csum_cnt_reg[p] <= csum_cnt_reg[p] + CNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                filt_cnt_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_fire && rx_bank && select_reg.port == 2'(p) &&
                    avs_address == PPD_OFS_FILT_CNT) begin
                    filt_cnt_reg[p] <= CNT_W'(ppd_merge(32'(filt_cnt_reg[p]), avs_writedata,
                                                        avs_byteenable));
                end else if (filter_drop[p] && filt_cnt_reg[p] != CNT_MAX) begin
                    filt_cnt_reg[p] <= filt_cnt_reg[p] + CNT_ONE;
                end
            end
        end
    end

    // Errored-frame report towards the receiving MAC
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mac_error_reg <= '0;
        end else begin
            mac_error_reg <= csum_drop | filter_drop;
        end
    end

    // ------------------------------------------------------------
    // Transmit parse enables
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                tx_parse_reg[p] <= PPD_TX_PARSE_RST;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (wr_fire && tx_bank && select_reg.port == 2'(p) &&
                    avs_address == PPD_OFS_TX_PARSE) begin
                    tx_parse_reg[p] <= 4'(ppd_merge(32'(tx_parse_reg[p]) << PPD_TX_PARSE_LSB,
                                                    avs_writedata, avs_byteenable)
                                          >> PPD_TX_PARSE_LSB);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit destination classifier
    // ------------------------------------------------------------
    function automatic logic ip6_group(input logic [127:0] addr, input logic [15:0] tail);
        // Any scope nibble is accepted
        return addr[127:120] == PPD_IP6_MCAST && addr[119:116] == 4'h0 &&
               addr[111:16] == 96'h0000_0000_0000_0000_0000_0000 && addr[15:0] == tail;
    endfunction

    function automatic logic ip_group(input ppd_tx_frame_type f,
                                      input logic [47:0] mac4, input logic [31:0] ip4,
                                      input logic [47:0] mac6, input logic [15:0] tail);
        logic v4_hit;
        logic v6_hit;
        v4_hit = !f.ipv6 && f.dst_mac == mac4 && f.ip4_dst == ip4;
        v6_hit = f.ipv6 && f.dst_mac == mac6 && ip6_group(f.ip6_dst, tail);
        return v4_hit || v6_hit;
    endfunction

    logic [NUM_PORTS-1:0] tx_match;

    always_comb begin
        tx_match = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (tx_parse_reg[p][PPD_TX_PEER_L2_IDX] &&
                tx_frame[p].dst_mac == PPD_MAC_L2_PEER) begin
                tx_match[p] = 1'b1;
            end
            if (tx_parse_reg[p][PPD_TX_GEN_L2_IDX] &&
                tx_frame[p].dst_mac == PPD_MAC_L2_GEN) begin
                tx_match[p] = 1'b1;
            end
            if (tx_parse_reg[p][PPD_TX_IP129_IDX] &&
                ip_group(tx_frame[p], PPD_MAC_V4_129, PPD_IP4_129,
                         PPD_MAC_V6_129, PPD_IP6_TAIL_129)) begin
                tx_match[p] = 1'b1;
            end
            if (tx_parse_reg[p][PPD_TX_IP130_IDX] &&
                ip_group(tx_frame[p], PPD_MAC_V4_130, PPD_IP4_130,
                         PPD_MAC_V6_130, PPD_IP6_TAIL_130)) begin
                tx_match[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_valid_reg <= '0;
            tx_ptp_reg <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                tx_valid_reg[p] <= tx_frame[p].valid;
                tx_ptp_reg[p] <= tx_frame[p].valid & tx_match[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata = readdata_reg;
    assign rx_mac_error = mac_error_reg;
    assign tx_ptp_valid = tx_valid_reg;
    assign tx_is_ptp = tx_ptp_reg;
    assign ptp_enable = enable_reg;

endmodule

// [test/ppd_port_capture_asserts.sv]
// Checker of bus timing, reserved fields and drop flags
`timescale 1ns/100ps
module ppd_port_capture_asserts import ppd_pkg::*; #(
    parameter int NUM_PORTS = 3,
    parameter int CNT_W = 32
) (
    // Bus
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [ppd_pkg::PPD_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Events
    input wire logic [NUM_PORTS-1:0] csum_drop,
    input wire logic [NUM_PORTS-1:0] filter_drop,
    input wire logic [NUM_PORTS-1:0] rx_mac_error,
    input wire logic [NUM_PORTS-1:0] tx_ptp_valid,
    input wire logic [NUM_PORTS-1:0] tx_is_ptp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic rq = avs_read | avs_write;
    wire logic ack = avs_read & !avs_waitrequest;
    property p_ans; rq && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_idle; !rq && avs_waitrequest |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_err; rx_mac_error == $past(csum_drop | filter_drop); endproperty
    a_err: assert property (p_err) else $error("mac error flag");
    property p_txv; (tx_is_ptp & ~tx_ptp_valid) == '0; endproperty
    a_txv: assert property (p_txv) else $error("ptp without valid");
    property p_sec; ack && avs_address == PPD_OFS_PD_SEC |-> avs_readdata[31:4] == '0; endproperty
    a_sec: assert property (p_sec) else $error("seconds spare bits");
    property p_ns; ack && avs_address == PPD_OFS_PD_NS |-> !avs_readdata[30]; endproperty
    a_ns: assert property (p_ns) else $error("nanoseconds bit 30");
    property p_lo; ack && avs_address == PPD_OFS_PD_CF_LO |-> avs_readdata[15:0] == '0; endproperty
    a_lo: assert property (p_lo) else $error("correction low bits");
    property p_cnt; ack && avs_address[9:3] == 7'h31 |-> (avs_readdata >> CNT_W) == '0;
    endproperty
    a_cnt: assert property (p_cnt) else $error("counter width");
endmodule
bind ppd_port_capture ppd_port_capture_asserts #(.NUM_PORTS(NUM_PORTS), .CNT_W(CNT_W)) chk_i (
    .clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .csum_drop, .filter_drop, .rx_mac_error, .tx_ptp_valid, .tx_is_ptp);

// [test/ppd_port_capture_tb.sv]
// Self-checking bench of the peer-delay capture bank
`timescale 1ns/100ps
module ppd_port_capture_tb;
import ppd_pkg::*;
logic clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, ptp_enable;
logic [9:0] avs_address = '0;
logic [31:0] avs_writedata = '0, avs_readdata, q;
logic [2:0] pdreq_valid = '0, csum_drop = '0, filter_drop = '0;
logic [2:0] rx_mac_error, tx_ptp_valid, tx_is_ptp;
ppd_pdreq_type [2:0] pdreq_time = '0;
ppd_tx_frame_type [2:0] tx_frame = '0;
int bad_count = 0, checked = 0, cycles = 0;
logic [9:0] adr [4] = '{PPD_OFS_PD_SEC, PPD_OFS_PD_NS, PPD_OFS_PD_CF_HI, PPD_OFS_PD_CF_LO};
logic [31:0] msk [4] = '{32'h0000_000F, 32'hBFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_0000};
ppd_port_capture #(.NUM_PORTS(3), .CNT_W(4)) ppd_port_capture_inst (.clk_sys, .resetn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .pdreq_valid, .pdreq_time, .csum_drop, .filter_drop, .rx_mac_error,
    .tx_frame, .tx_ptp_valid, .tx_is_ptp, .ptp_enable);
initial forever #25 clk_sys = ~clk_sys;
always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
        bad_count++;
        tally_and_finish();
    end
end
task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
        bad_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, exp);
endtask
task automatic txc(input logic [47:0] m, input logic v6, input logic [31:0] ip,
                   input logic [15:0] tail, input logic e);
    @(posedge clk_sys);
    tx_frame[0] <= {1'b1, v6, m, ip, 8'hFF, 8'h02, 96'h0, tail};
    @(posedge clk_sys);
    tx_frame[0].valid <= 1'b0;
    @(negedge clk_sys);
    chk({30'h0, tx_ptp_valid[0], tx_is_ptp[0]}, {30'h0, 1'b1, e});
endtask
task automatic pd_pulse();
    @(posedge clk_sys);
    pdreq_valid <= 3'h1;
    @(posedge clk_sys);
    pdreq_valid <= 3'h0;
endtask
initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    acc(1'b1, PPD_OFS_SELECT, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
        rdc(adr[i], 32'h0000_0000);
        acc(1'b1, adr[i], 32'hFFFF_FFFF);
        rdc(adr[i], msk[i]);
        acc(1'b1, adr[i], 32'h0000_0000);
    end
    rdc(10'h1F0, 32'h0000_0000);
    pdreq_time[0] <= {4'h5, 30'h1234_5678, 64'h1122_3344_5566_7788};
    pd_pulse();
    rdc(PPD_OFS_PD_SEC, 32'h0000_0000);
    acc(1'b1, PPD_OFS_PD_NS, 32'h8000_0000);
    pd_pulse();
    rdc(PPD_OFS_PD_SEC, 32'h0000_0005);
    rdc(PPD_OFS_PD_NS, 32'h9234_5678);
    rdc(PPD_OFS_PD_CF_HI, 32'h1122_3344);
    rdc(PPD_OFS_PD_CF_LO, 32'h5566_0000);
    acc(1'b1, PPD_OFS_SELECT, 32'h0000_0011);
    rdc(PPD_OFS_PD_SEC, 32'h0000_0000);
    acc(1'b1, PPD_OFS_SELECT, 32'h0000_0031);
    rdc(PPD_OFS_PD_CF_HI, 32'h0000_0000);
    acc(1'b1, PPD_OFS_SELECT, 32'h0000_0001);
    @(posedge clk_sys);
    csum_drop <= 3'h1;
    filter_drop <= 3'h1;
    repeat (3) @(posedge clk_sys);
    csum_drop <= 3'h0;
    @(negedge clk_sys);
    chk({29'h0, rx_mac_error}, 32'h0000_0001);
    repeat (17) @(posedge clk_sys);
    filter_drop <= 3'h0;
    rdc(PPD_OFS_CSUM_CNT, 32'h0000_0003);
    rdc(PPD_OFS_FILT_CNT, 32'h0000_000F);
    acc(1'b1, PPD_OFS_FILT_CNT, 32'h0000_0000);
    rdc(PPD_OFS_FILT_CNT, 32'h0000_0000);
    acc(1'b1, PPD_OFS_SELECT, 32'h0000_0002);
    rdc(PPD_OFS_TX_PARSE, 32'h0000_7000);
    txc(PPD_MAC_L2_PEER, 1'b0, 32'h0, 16'h0, 1'b1);
    txc(PPD_MAC_L2_GEN, 1'b0, 32'h0, 16'h0, 1'b1);
    txc(PPD_MAC_V4_129, 1'b0, PPD_IP4_129, 16'h0, 1'b1);
    txc(PPD_MAC_V4_129, 1'b0, PPD_IP4_130, 16'h0, 1'b0);
    txc(PPD_MAC_V6_129, 1'b1, 32'h0, PPD_IP6_TAIL_129, 1'b1);
    txc(PPD_MAC_V4_130, 1'b0, PPD_IP4_130, 16'h0, 1'b0);
    acc(1'b1, PPD_OFS_TX_PARSE, 32'h0000_0800);
    txc(PPD_MAC_L2_PEER, 1'b0, 32'h0, 16'h0, 1'b0);
    txc(PPD_MAC_V4_129, 1'b0, PPD_IP4_129, 16'h0, 1'b0);
    txc(PPD_MAC_V4_130, 1'b0, PPD_IP4_130, 16'h0, 1'b1);
    txc(PPD_MAC_V6_130, 1'b1, 32'h0, PPD_IP6_TAIL_130, 1'b1);
    // Global enable only after all mode bits are settled
    acc(1'b1, PPD_OFS_CMD_CTL, 32'h0000_0001);
    rdc(PPD_OFS_CMD_CTL, 32'h0000_0001);
    chk({31'h0, ptp_enable}, 32'h0000_0001);
    tally_and_finish();
end
endmodule
